// ---- hdl/gpc_pkg.sv ----
package gpc_pkg;
	localparam logic [15:0] CFG_ADDR = 16'h403D;
	localparam logic [15:0] IRQ_STAT_ADDR = 16'h4040;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'h4041;
	localparam logic [15:0] PIN_STAT_ADDR = 16'h4042;
	localparam int DIR_BIT = 15;
	localparam int PULL_HI = 14;
	localparam int PULL_LO = 13;
	localparam int MODE_BIT = 12;
	localparam int DOM_BIT = 11;
	localparam int POL_BIT = 10;
	localparam int OD_BIT = 9;
	localparam int ENA_BIT = 7;
	localparam int FN_HI = 3;
	localparam logic [15:0] CFG_RESET = 16'hA400;
	localparam logic [15:0] CFG_WMASK = 16'hFE8F;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam int CLK_HZ = 20_000_000;
	localparam int LONG_DB_US = 20_000;
	localparam int SHORT_DB_US = 100;
	localparam int LONG_DB_CYC = LONG_DB_US * (CLK_HZ / 1_000_000);
	localparam int SHORT_DB_CYC = SHORT_DB_US * (CLK_HZ / 1_000_000);
	typedef enum logic [3:0] {
		FN_GPIO_LONG = 4'h0, FN_GPIO = 4'h1, FN_ONOFF = 4'h2, FN_SLPWAKE = 4'h3,
		FN_SLPWAKE_LONG = 4'h4, FN_SLEEP = 4'h5, FN_PWRON = 4'h6, FN_WDOG = 4'h7,
		FN_VS1 = 4'h8, FN_VS2 = 4'h9, FN_HWEN1 = 4'hA, FN_HWEN2 = 4'hB,
		FN_HWCTL1 = 4'hC, FN_HWCTL2 = 4'hD, FN_HWCTL1_LONG = 4'hE, FN_HWCTL2_LONG = 4'hF
	} gpc_fn_t;
	localparam int N_IN = 16;
	localparam int N_OUT = 16;
endpackage : gpc_pkg

// ---- hdl/gpc_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpc_debounce #(
	parameter int LONG_CYC = 400_000,
	parameter int SHORT_CYC = 2_000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic din,
	input wire logic long_sel,
	output logic dout
);
	localparam int CW = $clog2(LONG_CYC + 1);
	initial begin
		if (LONG_CYC < 1 || SHORT_CYC < 1 || SHORT_CYC > LONG_CYC)
			$error("gpc_debounce: bad filter lengths");
	end
	logic [CW-1:0] cnt_r;
	logic dout_r;
	wire [CW-1:0] limit = long_sel ? CW'(LONG_CYC) : CW'(SHORT_CYC);
	wire differ = din != dout_r;
	wire done = cnt_r >= limit - CW'(1);
	// a level must hold for the whole window; any bounce restarts it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_r <= '0;
			dout_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= (differ && !done) ? cnt_r + CW'(1) : '0;
			if (differ && done)
				dout_r <= din;
		end
	end
	assign dout = dout_r;
endmodule : gpc_debounce
`default_nettype wire

// ---- hdl/gpc_pin_ctrl.sv ----
// Contract
// RULE1: enable 0 tristates pin; else direction bit 0 output, 1 input.
// RULE2: bits 14:13 pick bias: none, pull-down default, pull-up, 11 reserved.
// RULE3: mode 0 interrupts on one edge: rising if polarity 1, else falling.
// RULE4: mode 1 interrupts on both pin edges.
// RULE5: polarity 0 inverts pin active-low; 1 non-inverted, default.
// RULE6: driver bit 0 push-pull, 1 open-drain.
// RULE7: domain bit 0 digital buffer supply, 1 alternate pin supply.
// RULE8: input code 0 plain input long debounce, code 1 without.
// RULE9: input codes 2-6 power on/off, sleep/wake, long sleep/wake, sleep, power-on.
// RULE10: input code 7 watchdog reset, 8 and 9 voltage-scaling selects.
// RULE11: input codes 10-15 hardware enables, controls, long-debounced controls.
// RULE12: output code 0 register level, code 1 32.768kHz clock. Code 0 reads cfg bit 4, which the write mask holds at 0.
// RULE13: output codes 2-4 on, sleep, state-change indicators; 5-7 reserved.
// RULE14: output codes 8-9 scaling done flags, 10-11 external power enables.
// RULE15: output codes 12-15 supply good, power good, 2MHz clock, aux reset.
// RULE16: debounce lengths are parameters; filter precedes edge detect and routing.
// RULE17: detected edge leaves as a one-cycle event for interrupt collection.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_ctrl #(
	parameter int LONG_DB_CYC = gpc_pkg::LONG_DB_CYC,
	parameter int SHORT_DB_CYC = gpc_pkg::SHORT_DB_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_b,
	output logic pull_up_en,
	output logic pull_down_en,
	output logic supply_domain_sel,
	input wire logic [gpc_pkg::N_OUT-1:0] int_src,
	output logic [gpc_pkg::N_IN-1:0] int_dst,
	output logic pin_edge,
	output logic irq
);
	// int_src bit n is the internal signal for output code n (bits 0 and 5-7 unused)
	// int_dst bit n is the internal input for input code n (bits 0,1 also driven)
	initial begin
		if (LONG_DB_CYC < 1 || SHORT_DB_CYC < 1)
			$error("gpc_pin_ctrl: debounce counts must be positive");
	end

	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [1:0] sync_r;
	logic filt_d_r;
	logic [gpc_pkg::N_OUT-1:0] src_r;
	logic [gpc_pkg::N_IN-1:0] dst_r;
	logic pin_out_r;
	logic pin_oe_b_r;
	logic pu_r;
	logic pd_r;
	logic dom_r;
	logic edge_r;
	logic stat_r;
	logic mask_r;
	logic irq_r;
	logic [15:0] rdata_r;
	logic filt;

	wire pin_enable = cfg_r[gpc_pkg::ENA_BIT];
	wire pin_direction_select = cfg_r[gpc_pkg::DIR_BIT];
	wire [1:0] bias_resistor_select = cfg_r[gpc_pkg::PULL_HI:gpc_pkg::PULL_LO];
	wire edge_interrupt_mode = cfg_r[gpc_pkg::MODE_BIT];
	wire supply_domain_select = cfg_r[gpc_pkg::DOM_BIT];
	wire pin_polarity_select = cfg_r[gpc_pkg::POL_BIT];
	wire driver_type_select = cfg_r[gpc_pkg::OD_BIT];
	wire [3:0] pin_function_code = cfg_r[gpc_pkg::FN_HI:0];
	wire is_output = pin_enable && !pin_direction_select; // [RULE1]
	wire is_input = pin_enable && pin_direction_select; // [RULE1]

	// polarity maps electrical level onto logical assertion
	wire logic_level = pin_polarity_select ? filt : !filt; // [RULE5]

	// bus decode
	wire hit_cfg = addr == gpc_pkg::CFG_ADDR;
	wire hit_stat = addr == gpc_pkg::IRQ_STAT_ADDR;
	wire hit_mask = addr == gpc_pkg::IRQ_MASK_ADDR;
	wire hit_pin = addr == gpc_pkg::PIN_STAT_ADDR;
	assign cfg_nxt = (wr && hit_cfg) ? (wdata & gpc_pkg::CFG_WMASK) : cfg_r;
	wire [15:0] rd_mux = hit_cfg ? cfg_r :
		hit_stat ? {15'h0000, stat_r} :
		hit_mask ? {15'h0000, mask_r} :
		hit_pin ? {15'h0000, logic_level} : 16'h0000;

	// long filter for codes 0, 4, 14, 15; short filter otherwise
	wire long_sel = pin_function_code == gpc_pkg::FN_GPIO_LONG ||
		pin_function_code == gpc_pkg::FN_SLPWAKE_LONG ||
		pin_function_code == gpc_pkg::FN_HWCTL1_LONG ||
		pin_function_code == gpc_pkg::FN_HWCTL2_LONG; // [RULE8] [RULE9] [RULE11]

	gpc_debounce #(
		.LONG_CYC(LONG_DB_CYC),
		.SHORT_CYC(SHORT_DB_CYC)
	) u_db (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.din(sync_r[1]),
		.long_sel(long_sel),
		.dout(filt)
	); // [RULE16]

	wire rise = filt && !filt_d_r;
	wire fall = !filt && filt_d_r;
	wire edge_single = pin_polarity_select ? rise : fall; // [RULE3]
	wire edge_both = rise || fall; // [RULE4]
	wire edge_det = is_input && (edge_interrupt_mode ? edge_both : edge_single);

	// routed inputs, one-hot on the code
	logic [gpc_pkg::N_IN-1:0] dst_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < gpc_pkg::N_IN; gi++) begin : g_dst
			assign dst_nxt[gi] = is_input && pin_function_code == 4'(gi) &&
				logic_level; // [RULE9] [RULE10] [RULE11]
		end
	endgenerate

	// output function select; reserved codes 5-7 drive inactive
	wire reserved_fn = pin_function_code >= 4'h5 && pin_function_code <= 4'h7; // [RULE13]
	wire func_level = pin_function_code == 4'h0 ? cfg_r[4] :
		reserved_fn ? 1'b0 : src_r[pin_function_code]; // [RULE12] [RULE13] [RULE14] [RULE15]
	wire drive_level = pin_polarity_select ? func_level : !func_level; // [RULE5]
	// open drain only sinks; high is released to the pull
	wire oe_b_nxt = !is_output ||
		(driver_type_select && drive_level); // [RULE1] [RULE6]
	wire out_nxt = driver_type_select ? 1'b0 : drive_level; // [RULE6]

	wire stat_nxt = edge_det || (stat_r && !(rd && hit_stat));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_r <= gpc_pkg::CFG_RESET;
			sync_r <= 2'h0;
			filt_d_r <= 1'b0;
			src_r <= '0;
			dst_r <= '0;
			pin_out_r <= 1'b0;
			pin_oe_b_r <= 1'b1;
			pu_r <= 1'b0;
			pd_r <= 1'b1;
			dom_r <= 1'b0;
			edge_r <= 1'b0;
			stat_r <= 1'b0;
			mask_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else if (ce) begin
			cfg_r <= cfg_nxt;
			sync_r <= {sync_r[0], pin_in};
			filt_d_r <= filt;
			src_r <= int_src;
			dst_r <= dst_nxt;
			pin_out_r <= out_nxt;
			pin_oe_b_r <= oe_b_nxt;
			pu_r <= bias_resistor_select == gpc_pkg::PULL_UP; // [RULE2]
			pd_r <= bias_resistor_select == gpc_pkg::PULL_DOWN; // [RULE2]
			dom_r <= supply_domain_select; // [RULE7]
			edge_r <= edge_det; // [RULE17]
			stat_r <= stat_nxt;
			if (wr && hit_mask)
				mask_r <= wdata[0];
			irq_r <= stat_nxt && mask_r;
			rdata_r <= rd ? rd_mux : 16'h0000;
		end
	end

	assign rdata = rdata_r;
	assign pin_out = pin_out_r;
	assign pin_oe_b = pin_oe_b_r;
	assign pull_up_en = pu_r;
	assign pull_down_en = pd_r;
	assign supply_domain_sel = dom_r;
	assign int_dst = dst_r;
	assign pin_edge = edge_r;
	assign irq = irq_r;
endmodule : gpc_pin_ctrl
`default_nettype wire

// ---- testbench/gpc_pin_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_ctrl_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic pin_out,
	input wire logic pin_oe_b,
	input wire logic pull_up_en,
	input wire logic pull_down_en,
	input wire logic supply_domain_sel,
	input wire logic [15:0] int_dst,
	input wire logic pin_edge
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// outputs trail a config write by two cycles
	sequence cfg_wr(c);
		wr && addr == gpc_pkg::CFG_ADDR && c;
	endsequence
	chk_tristate_off: assert property (cfg_wr(!wdata[7]) |-> ##2 pin_oe_b)
		else $error("enable low but pin driven");
	chk_input_released: assert property (cfg_wr(wdata[15]) |-> ##2 pin_oe_b)
		else $error("input pin driven");
	chk_push_pull: assert property (cfg_wr(!wdata[15] && wdata[7] && !wdata[9]) |-> ##2 !pin_oe_b)
		else $error("push-pull output not driven");
	chk_open_drain: assert property (cfg_wr(!wdata[15] && wdata[9]) |-> ##2 !pin_out)
		else $error("open-drain drives high");
	chk_bias_decode: assert property (cfg_wr(1'h1) |-> ##2 pull_up_en == ($past(wdata[14:13], 2) == 2'h2)
		&& pull_down_en == ($past(wdata[14:13], 2) == 2'h1))
		else $error("bias select wrong");
	chk_domain_follows: assert property (cfg_wr(1'h1) |-> ##2 supply_domain_sel == $past(wdata[11], 2))
		else $error("supply domain wrong");
	chk_edge_single: assert property (pin_edge |=> !pin_edge)
		else $error("edge event too long");
	chk_route_onehot: assert property ($onehot0(int_dst))
		else $error("several routes at once");
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside slot");
endmodule : gpc_pin_ctrl_props
bind gpc_pin_ctrl gpc_pin_ctrl_props chk_u (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
	.pin_out, .pin_oe_b, .pull_up_en, .pull_down_en, .supply_domain_sel, .int_dst, .pin_edge);
`default_nettype wire

// ---- testbench/gpc_pin_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_host (
	input wire logic clk,
	input wire logic drv_en,
	input wire logic drv_val,
	input wire logic pin_out,
	input wire logic pin_oe_b,
	input wire logic pull_up_en,
	input wire logic pull_down_en,
	output logic pin_in
);
	logic last_r = 1'h0;
	// a floating wire toggles so a stale level never passes
	assign pin_in = !pin_oe_b ? pin_out : drv_en ? drv_val : pull_up_en ? 1'h1 :
		pull_down_en ? 1'h0 : ~last_r;
	always @(posedge clk) last_r <= pin_in;
endmodule : gpc_pin_host
`default_nettype wire

// ---- testbench/gpc_pin_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_ctrl_test;
	logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, drv_en = 1'h0, drv_val = 1'h0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, int_src = 16'h0000, rdata, int_dst;
	logic pin_in, pin_out, pin_oe_b, pull_up_en, pull_down_en, supply_domain_sel, pin_edge, irq;
	int bad_count = 0, comparisons = 0, cycles = 0;
	always #25 clk = ~clk;
	always @(posedge clk) if (++cycles > 6000) give_verdict(1'h1);
	gpc_pin_ctrl #(.LONG_DB_CYC(4), .SHORT_DB_CYC(2)) dut_u (.clk, .rst_b, .ce(1'h1), .addr,
		.wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe_b, .pull_up_en, .pull_down_en,
		.supply_domain_sel, .int_src, .int_dst, .pin_edge, .irq);
	gpc_pin_host host_u (.clk, .drv_en, .drv_val, .pin_out, .pin_oe_b, .pull_up_en,
		.pull_down_en, .pin_in);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		{addr, wdata, wr} <= {a, d, 1'h1};
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		{addr, rd} <= {a, 1'h1};
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		chk(rdata, e);
	endtask : rd_chk
	task automatic edge_chk(input logic v, input logic ei, input logic es);
		@(posedge clk);
		drv_val <= v;
		settle(10);
		chk({15'h0000, irq}, {15'h0000, ei});
		rd_chk(gpc_pkg::IRQ_STAT_ADDR, {15'h0000, es});
	endtask : edge_chk
	task automatic give_verdict(input logic hung);
		if (hung) bad_count++;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20) @(posedge clk);
		{rst_b, drv_en} <= 2'h3;
		rd_chk(gpc_pkg::CFG_ADDR, 16'hA400);
		wr_reg(gpc_pkg::IRQ_MASK_ADDR, 16'h0001);
		rd_chk(gpc_pkg::IRQ_MASK_ADDR, 16'h0001);
		wr_reg(gpc_pkg::CFG_ADDR, 16'h8481);
		edge_chk(1'h0, 1'h0, 1'h0);
		edge_chk(1'h1, 1'h1, 1'h1);
		edge_chk(1'h0, 1'h0, 1'h0);
		wr_reg(gpc_pkg::CFG_ADDR, 16'h9481);
		edge_chk(1'h1, 1'h1, 1'h1);
		edge_chk(1'h0, 1'h1, 1'h1);
		wr_reg(gpc_pkg::IRQ_MASK_ADDR, 16'h0000);
		edge_chk(1'h1, 1'h0, 1'h1);
		wr_reg(gpc_pkg::CFG_ADDR, 16'hFFFF);
		rd_chk(gpc_pkg::CFG_ADDR, 16'hFE8F);
		rd_chk(16'h4043, 16'h0000);
		$display("irq and register tests done");
		for (int p = 0; p < 4; p++) begin
			wr_reg(gpc_pkg::CFG_ADDR, {1'h1, p[1:0], 1'h0, p[0], 11'h000});
			settle(2);
			chk({pull_up_en, pull_down_en, supply_domain_sel}, {p == 2, p == 1, p[0]});
		end
		for (int k = 0; k < 32; k++) begin
			@(posedge clk);
			drv_val <= k[4];
			wr_reg(gpc_pkg::CFG_ADDR, {12'h848, k[3:0]});
			settle(12);
			chk(int_dst, k[4] ? 16'h0001 << k[3:0] : 16'h0000);
		end
		$display("bias and input tests done");
		for (int k = 0; k < 64; k++) begin
			logic lv;
			lv = (k[3:0] inside {[1:4], [8:15]}) ^ !k[4];
			@(posedge clk);
			{drv_en, int_src} <= {1'h0, 16'h0001 << k[3:0]};
			wr_reg(gpc_pkg::CFG_ADDR, {5'h00, k[4], k[5], 2'h1, 3'h0, k[3:0]});
			settle(4);
			chk({pin_out, pin_oe_b}, {lv & !k[5], lv & k[5]});
		end
		$display("output test done");
		give_verdict(1'h0);
	end
endmodule : gpc_pin_ctrl_test
`default_nettype wire
